// ### fp_check_defines.svh
// constants for the floating-point access check and lazy preservation block
`ifndef FP_CHECK_DEFINES_SVH
`define FP_CHECK_DEFINES_SVH

// coprocessor access field encodings
`define ACC_DENIED      2'h0
`define ACC_PRIV_ONLY   2'h1
`define ACC_RESERVED    2'h2
`define ACC_FULL        2'h3

// system register index of the status and control register
`define SYSREG_FSC_IDX  4'h1

// preservation layout: sixteen words, then status word at base plus 0x40
`define SAVE_WORDS      5'h10
`define SAVE_FSC_OFS    32'h0000_0040

// lockup branch target
`define LOCKUP_ADDR     32'h0fff_fffe

// reset value of the status and control register
`define FSC_RESET       32'h0000_0000

`endif

// ### fp_check_pkg.sv
// types shared by the floating-point check block
package fp_check_pkg;

	// exception reported to the exception logic
	typedef enum logic [2:0] {
		EXC_NONE     = 3'h0,
		EXC_USAGE    = 3'h1,
		EXC_MEMMGMT  = 3'h2,
		EXC_BUS      = 3'h3,
		EXC_HARD     = 3'h4,
		EXC_MONITOR  = 3'h5
	} exc_t;

	// sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_STORE = 4'b0010,
		ST_FAULT = 4'b0100,
		ST_DONE  = 4'b1000
	} seq_state_t;

endpackage : fp_check_pkg

// ### fp_access_decode.sv
// decoder of the coprocessor access fields
`timescale 1ns/1ps
`include "fp_check_defines.svh"

module fp_access_decode (
	input  wire logic [1:0] i_coproc_a,
	input  wire logic [1:0] i_coproc_b,
	input  wire logic       i_privileged,
	output logic            o_denied,
	output logic            o_mismatch
);

	// both fields should match; a mismatch is flagged, field a decides
	assign o_mismatch = (i_coproc_a != i_coproc_b);

	// 00 and reserved 10 always deny, 01 denies unprivileged, 11 permits
	assign o_denied = (i_coproc_a == `ACC_DENIED) ||
	                  (i_coproc_a == `ACC_RESERVED) ||
	                  ((i_coproc_a == `ACC_PRIV_ONLY) && !i_privileged);

endmodule : fp_access_decode

// ### fp_access_check_lazy_save.sv
// floating-point access check, lazy state preservation and its faults
// What this block does
// - mismatched access fields are unpredictable; field a decides, mismatch flagged.
// - field 00 faults always, 01 faults unprivileged, 11 permits access.
// - each fp instruction checks access, then runs any outstanding lazy save.
// - sixteen singles at base plus four times index, status at base plus 0x40.
// - stores are unprivileged when recorded user indicator is one.
// - check priority is forced to minus one when hard_fault_c ready is zero.
// - lazy-active clears only after all stores or fault abandonment.
// - only memmgmt, bus and monitor faults arise; dedicated escalation.
// - monitor exception is ignored when monitor ready is zero.
// - memmgmt and bus faults set their lazy error flags.
// - fault with handler not ready escalates to hard fault, sets forced.
// - negative priority with hard_fault_c not ready enters lockup at 0xFFFFFFE.
// - exception enters if enabled and higher priority, else pends.
// - system register index 0001 is status/control; others reserved.
// - exactly one system register exists in that space.
// - thirty-two singles overlay sixteen doubles in pairs.
// - ready bits set with hard_fault_c ready clear are unpredictable.
`timescale 1ns/1ps
`include "fp_check_defines.svh"

module fp_access_check_lazy_save #(
	parameter int PRIO_W = 9
) (
	input  wire logic              i_clk,
	input  wire logic              i_rst_b,
	// instruction side
	input  wire logic              i_fp_instr,
	input  wire logic [1:0]        i_coproc_a,
	input  wire logic [1:0]        i_coproc_b,
	input  wire logic              i_privileged,
	// system register moves
	input  wire logic              i_sysreg_wr,
	input  wire logic              i_sysreg_rd,
	input  wire logic [3:0]        i_sysreg_idx,
	input  wire logic [31:0]       i_sysreg_wdata,
	// register file writes from the datapath
	input  wire logic              i_reg_wr,
	input  wire logic [4:0]        i_reg_idx,
	input  wire logic [31:0]       i_reg_wdata,
	input  wire logic [3:0]        i_dreg_idx,
	// float context control state
	input  wire logic              i_lazy_set,
	input  wire logic [31:0]       i_context_address,
	input  wire logic              i_user_rec,
	input  wire logic              i_hard_fault_c_ready,
	input  wire logic              i_memmgmt_ready,
	input  wire logic              i_bus_fault_b_ready,
	input  wire logic              i_monitor_ready,
	// priority and enables from the exception logic
	input  wire logic signed [PRIO_W-1:0] i_exec_prio,
	input  wire logic signed [PRIO_W-1:0] i_memmgmt_prio,
	input  wire logic signed [PRIO_W-1:0] i_bus_prio,
	input  wire logic signed [PRIO_W-1:0] i_monitor_prio,
	input  wire logic              i_memmgmt_en,
	input  wire logic              i_bus_en,
	input  wire logic              i_monitor_en,
	// memory side
	input  wire logic              i_mem_ready,
	input  wire logic              i_mem_mm_fault,
	input  wire logic              i_mem_bus_fault,
	input  wire logic              i_mem_watch,
	input  wire logic              i_status_clear,
	output logic                   o_mem_req,
	output logic [31:0]            o_mem_addr,
	output logic [31:0]            o_mem_wdata,
	output logic                   o_mem_unpriv,
	output logic signed [PRIO_W-1:0] o_check_prio,
	// results
	output logic                   o_instr_go,
	output logic                   o_stall,
	output logic                   o_no_coproc_flag,
	output logic                   o_config_error,
	output logic                   o_lazy_save_active,
	output logic                   o_memmgmt_lazy_error,
	output logic                   o_bus_lazy_error,
	output logic                   o_hard_forced,
	output logic                   o_lockup,
	output logic [31:0]            o_lockup_addr,
	output fp_check_pkg::exc_t     o_exc,
	output logic                   o_exc_enter,
	output logic                   o_exc_pend,
	output logic [31:0]            o_sysreg_rdata,
	output logic [63:0]            o_dreg_rdata
);

	//////////////////////////////////////////////////////////////////////
	// storage and state

	logic [31:0]              sreg [32];
	logic [31:0]              float_status_control;
	logic [4:0]               word_cnt;
	fp_check_pkg::seq_state_t state;
	fp_check_pkg::seq_state_t next_state;
	fp_check_pkg::exc_t       fault_exc;
	logic                     no_coproc;
	logic                     lazy_active;
	logic                     mm_err;
	logic                     bus_err;
	logic                     forced;
	logic                     lockup;
	logic [31:0]              mem_addr;
	logic [31:0]              mem_wdata;
	logic                     exc_enter;
	logic                     exc_pend;
	fp_check_pkg::exc_t       exc;
	logic [31:0]              rdata;

	//////////////////////////////////////////////////////////////////////
	// access decode

	wire access_denied;
	wire cfg_mismatch;

	fp_access_decode u_decode (
		.i_coproc_a   (i_coproc_a),
		.i_coproc_b   (i_coproc_b),
		.i_privileged (i_privileged),
		.o_denied     (access_denied),
		.o_mismatch   (cfg_mismatch)
	);

	//////////////////////////////////////////////////////////////////////
	// combinational decisions

	// check first, then save if lazy is pending before the instruction
	wire start_save  = i_fp_instr && !access_denied && lazy_active &&
	                   (state == fp_check_pkg::ST_IDLE);
	wire take_no_coproc_flag   = i_fp_instr && access_denied &&
	                   (state == fp_check_pkg::ST_IDLE);
	wire in_store    = (state == fp_check_pkg::ST_STORE);
	wire last_word   = (word_cnt == `SAVE_WORDS);
	wire store_ok    = in_store && i_mem_ready && !i_mem_mm_fault &&
	                   !i_mem_bus_fault;
	// bus or protection fault abandons the save
	wire store_abort = in_store && (i_mem_mm_fault || i_mem_bus_fault);
	// watchpoint hit only counts when the monitor handler can run
	wire watch_hit   = store_ok && i_mem_watch && i_monitor_ready;
	wire sysreg_sel  = (i_sysreg_idx == `SYSREG_FSC_IDX);
	// writes of the only system register, allowed only with access on
	wire fsc_write   = i_sysreg_wr && sysreg_sel && !access_denied;

	// address of the current preservation word
	function automatic logic [31:0] save_addr(input logic [31:0] base,
	                                          input logic [4:0] idx);
		save_addr = (idx == `SAVE_WORDS) ? base + `SAVE_FSC_OFS :
		            base + {25'h0, idx, 2'h0};
	endfunction : save_addr

	// pick the fault, escalating when its handler is not ready
	wire [2:0] raw_exc = i_mem_mm_fault ? fp_check_pkg::EXC_MEMMGMT :
	                     i_mem_bus_fault ? fp_check_pkg::EXC_BUS :
	                     fp_check_pkg::EXC_MONITOR;
	wire escalate = (i_mem_mm_fault && !i_memmgmt_ready) ||
	                (!i_mem_mm_fault && i_mem_bus_fault &&
	                 !i_bus_fault_b_ready);
	wire fault_now = store_abort || watch_hit;

	// group priority and enable of the resulting exception
	logic signed [PRIO_W-1:0] res_prio;
	logic                     res_en;
	always_comb begin
		case (fault_exc)
			fp_check_pkg::EXC_MEMMGMT: begin
				res_prio = i_memmgmt_prio;
				res_en   = i_memmgmt_en;
			end
			fp_check_pkg::EXC_BUS: begin
				res_prio = i_bus_prio;
				res_en   = i_bus_en;
			end
			fp_check_pkg::EXC_MONITOR: begin
				res_prio = i_monitor_prio;
				res_en   = i_monitor_en;
			end
			fp_check_pkg::EXC_HARD: begin
				res_prio = -PRIO_W'(1);
				res_en   = 1'b1;
			end
			default: begin
				res_prio = i_exec_prio;
				res_en   = 1'b0;
			end
		endcase
	end

	wire in_fault  = (state == fp_check_pkg::ST_FAULT);
	wire go_lock   = in_fault && (i_exec_prio < 0) &&
	                 !i_hard_fault_c_ready;
	wire preempt   = res_en && (res_prio < i_exec_prio);

	//////////////////////////////////////////////////////////////////////
	// sequencer

	always_comb begin
		case (state)
			fp_check_pkg::ST_IDLE:
				next_state = start_save ? fp_check_pkg::ST_STORE :
				             fp_check_pkg::ST_IDLE;
			fp_check_pkg::ST_STORE:
				next_state = fault_now ? fp_check_pkg::ST_FAULT :
				             (store_ok && last_word) ?
				             fp_check_pkg::ST_DONE :
				             fp_check_pkg::ST_STORE;
			fp_check_pkg::ST_FAULT:
				next_state = fp_check_pkg::ST_DONE;
			fp_check_pkg::ST_DONE:
				next_state = fp_check_pkg::ST_IDLE;
			default:
				next_state = fp_check_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state <= fp_check_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// word counter walks 0..16; the status word is the last
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			word_cnt <= 5'h0;
		end else if (start_save) begin
			word_cnt <= 5'h0;
		end else if (store_ok && !last_word) begin
			word_cnt <= word_cnt + 5'h1;
		end
	end

	wire [4:0] next_word = start_save ? 5'h0 :
	                       (store_ok && !last_word) ? word_cnt + 5'h1 :
	                       word_cnt;

	// memory request data held in flops; address follows the counter
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mem_addr  <= 32'h0;
			mem_wdata <= 32'h0;
		end else begin
			mem_addr  <= save_addr(i_context_address, next_word);
			mem_wdata <= (next_word == `SAVE_WORDS) ? float_status_control :
			             sreg[next_word];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// lazy flag: set wins over the end-of-save clear

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lazy_active <= 1'b0;
		end else if (i_lazy_set) begin
			lazy_active <= 1'b1;
		end else if (state == fp_check_pkg::ST_DONE) begin
			lazy_active <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// sticky status flags; a fresh event beats a clear

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			no_coproc <= 1'b0;
			mm_err    <= 1'b0;
			bus_err   <= 1'b0;
			forced    <= 1'b0;
		end else begin
			no_coproc <= take_no_coproc_flag || (no_coproc && !i_status_clear);
			mm_err    <= (store_abort && i_mem_mm_fault) ||
			             (mm_err && !i_status_clear);
			bus_err   <= (store_abort && !i_mem_mm_fault &&
			              i_mem_bus_fault) ||
			             (bus_err && !i_status_clear);
			forced    <= (store_abort && escalate) ||
			             (forced && !i_status_clear);
		end
	end

	// capture the resulting exception when the save is abandoned
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fault_exc <= fp_check_pkg::EXC_NONE;
		end else if (fault_now) begin
			fault_exc <= escalate ? fp_check_pkg::EXC_HARD :
			             fp_check_pkg::exc_t'(raw_exc);
		end
	end

	// exception outputs: fault results pulse one cycle, usage entry lasts while the denied instruction is held; lockup holds until reset
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			exc       <= fp_check_pkg::EXC_NONE;
			exc_enter <= 1'b0;
			exc_pend  <= 1'b0;
			lockup    <= 1'b0;
		end else begin
			exc       <= take_no_coproc_flag ? fp_check_pkg::EXC_USAGE :
			             in_fault ? fault_exc : fp_check_pkg::EXC_NONE;
			exc_enter <= take_no_coproc_flag || (in_fault && !go_lock && preempt);
			exc_pend  <= in_fault && !go_lock && !preempt;
			lockup    <= lockup || go_lock;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// register file and status/control register

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			float_status_control <= `FSC_RESET;
		end else if (fsc_write) begin
			float_status_control <= i_sysreg_wdata;
		end
	end

	// singles kept after a save; contents count as unknown to software
	always_ff @(posedge i_clk) begin
		if (i_reg_wr) begin
			sreg[i_reg_idx] <= i_reg_wdata;
		end
	end

	// reserved indices read zero
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rdata <= 32'h0;
		end else if (i_sysreg_rd) begin
			rdata <= sysreg_sel ? float_status_control : 32'h0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// outputs

	assign o_mem_req            = in_store;
	assign o_mem_addr           = mem_addr;
	assign o_mem_wdata          = mem_wdata;
	assign o_mem_unpriv         = i_user_rec;
	assign o_check_prio         = i_hard_fault_c_ready ? i_exec_prio :
	                              -PRIO_W'(1);
	assign o_instr_go           = i_fp_instr && !access_denied &&
	                              !lazy_active &&
	                              (state == fp_check_pkg::ST_IDLE);
	assign o_stall              = (state != fp_check_pkg::ST_IDLE) ||
	                              start_save;
	assign o_no_coproc_flag     = no_coproc;
	assign o_config_error       = cfg_mismatch ||
	                              ((i_monitor_ready || i_bus_fault_b_ready ||
	                                i_memmgmt_ready) &&
	                               !i_hard_fault_c_ready);
	assign o_lazy_save_active   = lazy_active;
	assign o_memmgmt_lazy_error = mm_err;
	assign o_bus_lazy_error     = bus_err;
	assign o_hard_forced        = forced;
	assign o_lockup             = lockup;
	assign o_lockup_addr        = `LOCKUP_ADDR;
	assign o_exc                = exc;
	assign o_exc_enter          = exc_enter;
	assign o_exc_pend           = exc_pend;
	assign o_sysreg_rdata       = rdata;
	assign o_dreg_rdata         = {sreg[{i_dreg_idx, 1'b1}],
	                               sreg[{i_dreg_idx, 1'b0}]};

endmodule : fp_access_check_lazy_save

// ### fp_lazy_monitor.sv
// concurrent checks on the fp access check and lazy preservation block
`timescale 1ns/1ps

module fp_lazy_monitor #(
	parameter int PRIO_W = 9
) (
	input wire logic                     i_clk,
	input wire logic                     i_rst_b,
	input wire logic [1:0]               i_coproc_a,
	input wire logic [31:0]              i_context_address,
	input wire logic                     i_user_rec,
	input wire logic                     i_hard_fault_c_ready,
	input wire logic                     i_memmgmt_ready,
	input wire logic                     i_monitor_ready,
	input wire logic signed [PRIO_W-1:0] i_exec_prio,
	input wire logic                     i_mem_ready,
	input wire logic                     i_mem_mm_fault,
	input wire logic                     i_mem_bus_fault,
	input wire logic                     i_mem_watch,
	input wire logic                     o_mem_req,
	input wire logic [31:0]              o_mem_addr,
	input wire logic                     o_mem_unpriv,
	input wire logic signed [PRIO_W-1:0] o_check_prio,
	input wire logic                     o_instr_go,
	input wire logic                     o_lazy_save_active,
	input wire logic                     o_memmgmt_lazy_error,
	input wire logic                     o_hard_forced,
	input wire logic                     o_lockup
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	////////////////////////////////////////
	// a store taken with no fault; an ignored watchpoint still counts
	sequence store_ok;
		o_mem_req && i_mem_ready && !i_mem_mm_fault && !i_mem_bus_fault
			&& !(i_mem_watch && i_monitor_ready);
	endsequence
	sequence last_ok;
		store_ok ##0 o_mem_addr == i_context_address + 32'h40;
	endsequence
	sequence store_mm;
		o_mem_req && i_mem_ready && i_mem_mm_fault;
	endsequence

	////////////////////////////////////////
	a_go_needs_access: assert property (o_instr_go |-> i_coproc_a[0])
		else $error("instruction issued with access denied");
	a_first_word: assert property ($rose(o_mem_req)
		|-> o_mem_addr == i_context_address)
		else $error("save did not start at the area base");
	a_next_word: assert property (store_ok |=> o_mem_req
		&& o_mem_addr == $past(o_mem_addr) + 32'h4
		|| $past(o_mem_addr) == i_context_address + 32'h40)
		else $error("save address did not step by four");
	a_unpriv_store: assert property (o_mem_req
		|-> o_mem_unpriv == i_user_rec)
		else $error("store privilege differs from recorded mode");
	a_prio_forced: assert property (o_check_prio
		== (i_hard_fault_c_ready ? i_exec_prio : -1))
		else $error("check priority wrong");
	a_lazy_held: assert property (o_mem_req |-> o_lazy_save_active)
		else $error("lazy flag dropped during stores");
	a_lazy_clears: assert property (last_ok
		|=> o_lazy_save_active ##1 !o_lazy_save_active)
		else $error("lazy flag not cleared after last store");
	a_mm_error: assert property (store_mm |=> o_memmgmt_lazy_error)
		else $error("memmgmt lazy error not set");
	a_forced_flag: assert property (store_mm ##0 !i_memmgmt_ready
		|=> o_hard_forced)
		else $error("forced escalation flag not set");
	a_lockup_entry: assert property (store_mm
		##0 (!i_hard_fault_c_ready && i_exec_prio < 0) |=> ##1 o_lockup)
		else $error("lockup not entered");
endmodule : fp_lazy_monitor

bind fp_access_check_lazy_save fp_lazy_monitor #(.PRIO_W(PRIO_W)) mon (
	.i_clk, .i_rst_b, .i_coproc_a, .i_context_address, .i_user_rec,
	.i_hard_fault_c_ready, .i_memmgmt_ready, .i_monitor_ready, .i_exec_prio,
	.i_mem_ready, .i_mem_mm_fault, .i_mem_bus_fault, .i_mem_watch,
	.o_mem_req, .o_mem_addr, .o_mem_unpriv, .o_check_prio, .o_instr_go,
	.o_lazy_save_active, .o_memmgmt_lazy_error, .o_hard_forced, .o_lockup
);

// ### fp_mem_model.sv
// memory-side partner model answering lazy preservation stores
`timescale 1ns/1ps

module fp_mem_model (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_req,
	input  wire logic [31:0] i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_stall,
	input  wire logic [1:0]  i_kind,
	input  wire logic [4:0]  i_word,
	output logic             o_ready,
	output logic             o_mm_fault,
	output logic             o_bus_fault,
	output logic             o_watch
);
	logic [31:0] saved_addr [17];
	logic [31:0] saved_data [17];
	logic [4:0]  cnt;
	logic [1:0]  phase;
	logic        hit;

	////////////////////////////////////////
	// slow mode answers one cycle in four; ready toggles while idle so a
	// stale level is never taken for an answer
	assign o_ready     = i_req ? (!i_stall || phase == 2'h3) : phase[0];
	assign hit         = i_req && o_ready && cnt == i_word;
	// only store faults and watchpoint hits come from this side
	assign o_mm_fault  = hit && i_kind == 2'h1;
	assign o_bus_fault = hit && i_kind == 2'h2;
	assign o_watch     = hit && i_kind == 2'h3;

	////////////////////////////////////////
	// record every store that was taken, in arrival order
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt <= 5'h0;
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
			if (i_req && o_ready && !o_mm_fault && !o_bus_fault) begin
				saved_addr[cnt] <= i_addr;
				saved_data[cnt] <= i_wdata;
				cnt <= cnt + 5'h1;
			end
		end
	end
endmodule : fp_mem_model

// ### tb_top.sv
// self-checking bench for the fp access check and lazy preservation block
`timescale 1ns/1ps
`include "fp_check_defines.svh"

module tb_top;
	logic i_clk, i_rst_b, i_fp_instr, i_privileged, i_sysreg_wr, i_sysreg_rd;
	logic i_reg_wr, i_lazy_set, i_user_rec, i_hard_fault_c_ready, i_bus_en;
	logic i_memmgmt_ready, i_bus_fault_b_ready, i_monitor_ready, i_memmgmt_en;
	logic i_monitor_en, i_mem_ready, i_mem_mm_fault, i_mem_bus_fault;
	logic i_mem_watch, i_status_clear, o_mem_req, o_mem_unpriv, o_instr_go;
	logic o_stall, o_no_coproc_flag, o_config_error, o_lazy_save_active;
	logic o_memmgmt_lazy_error, o_bus_lazy_error, o_hard_forced, o_lockup;
	logic o_exc_enter, o_exc_pend, stall, went, deny;
	logic              lk_d = 1'b0;
	logic [1:0]        i_coproc_a, i_coproc_b, kind;
	logic [3:0]        i_sysreg_idx, i_dreg_idx;
	logic [4:0]        i_reg_idx, fword;
	logic [31:0]       i_sysreg_wdata, i_reg_wdata, i_context_address;
	logic [31:0]       o_mem_addr, o_mem_wdata, o_lockup_addr, o_sysreg_rdata;
	logic [31:0]       seed, fsc;
	logic [31:0]       sreg [16];
	logic [63:0]       o_dreg_rdata;
	logic signed [8:0] i_exec_prio, i_memmgmt_prio, i_bus_prio;
	logic signed [8:0] i_monitor_prio, o_check_prio;
	fp_check_pkg::exc_t o_exc;
	logic [5:0]        q [$];
	int                bad_count = 0, checks = 0, evcnt = 0, cyc = 0;

	fp_access_check_lazy_save #(.PRIO_W(9)) dut (.*);
	fp_mem_model mem (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(o_mem_req),
		.i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_stall(stall),
		.i_kind(kind), .i_word(fword), .o_ready(i_mem_ready),
		.o_mm_fault(i_mem_mm_fault), .o_bus_fault(i_mem_bus_fault),
		.o_watch(i_mem_watch));

	////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
	endfunction : lfsr

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		if (bad_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up

	task automatic do_reset();
		i_rst_b <= 1'b0;
		repeat (4) @(posedge i_clk);
		i_rst_b <= 1'b1;
		@(posedge i_clk);
	endtask : do_reset

	// one move; a read is compared at the edge after its result lands
	task automatic sys_move(input logic wr, input logic [3:0] idx,
			input logic [31:0] d);
		{i_sysreg_wr, i_sysreg_rd} <= {wr, !wr};
		i_sysreg_idx <= idx;
		i_sysreg_wdata <= d;
		@(posedge i_clk);
		{i_sysreg_wr, i_sysreg_rd} <= 2'b00;
		@(posedge i_clk);
	endtask : sys_move

	// hold an fp instruction until it issues or an exception shows up
	task automatic run_instr(input int hold, output logic go);
		int e0;
		e0 = evcnt;
		i_fp_instr <= 1'b1;
		for (int n = 0; n < hold && !o_instr_go && evcnt == e0; n++) begin
			@(posedge i_clk);
		end
		go = o_instr_go;
		i_fp_instr <= 1'b0;
	endtask : run_instr

	// arm a lazy save, let the memory side inject one event, then compare
	task automatic save_case(input logic rst, input logic [1:0] k,
			input logic [4:0] w, input logic [3:0] rdy,
			input logic signed [8:0] ep, input logic signed [8:0] p,
			input logic [5:0] exp);
		logic go;
		if (rst) begin
			do_reset();
		end
		seed = lfsr(seed);
		{kind, fword, i_exec_prio} <= {k, w, ep};
		{i_hard_fault_c_ready, i_memmgmt_ready, i_bus_fault_b_ready,
			i_monitor_ready} <= rdy;
		{i_memmgmt_prio, i_bus_prio, i_monitor_prio} <= {p, p, p};
		i_context_address <= {seed[31:2], 2'h0};
		{i_user_rec, stall, i_lazy_set} <= {seed[1:0], 1'b1};
		@(posedge i_clk);
		i_lazy_set <= 1'b0;
		if (exp != 6'h0) begin
			q.push_back(exp);
		end
		run_instr(300, go);
		repeat (3) @(posedge i_clk);
		check(q.size(), 0);
		check(o_config_error, |rdy[2:0] && !rdy[3]);
		if (exp == 6'h0) begin
			check({go, o_lazy_save_active, o_stall}, 3'b100);
		end else if (exp == 6'h20) begin
			check({o_lockup_addr, o_hard_forced}, {`LOCKUP_ADDR, 1'b1});
		end else if (k != 2'h3) begin
			check({o_memmgmt_lazy_error, o_bus_lazy_error, o_hard_forced,
				o_lazy_save_active}, {k == 2'h1, k == 2'h2, !rdy[3 - k],
				1'b0});
		end
	endtask : save_case

	////////////////////////////////////////
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	// ceiling far above the few hundred cycles the sequence needs
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 8000) begin
			bad_count++;
			wrap_up();
		end
	end

	// event code: lockup, enter, pend, then the exception number
	always @(posedge i_clk) begin
		#1;
		if (o_exc_enter || o_exc_pend || (o_lockup && !lk_d)) begin
			evcnt++;
			check(o_lockup ? 6'h20 : {1'b0, o_exc_enter, o_exc_pend, o_exc},
				q.size() ? q.pop_front() : 6'h3f);
		end
		lk_d = o_lockup;
	end

	////////////////////////////////////////
	initial begin
		{i_rst_b, i_fp_instr, i_privileged, i_sysreg_wr, i_sysreg_rd} = '0;
		{i_reg_wr, i_lazy_set, i_user_rec, i_status_clear, stall} = '0;
		{i_hard_fault_c_ready, i_memmgmt_ready, i_bus_fault_b_ready} = 3'h7;
		{i_monitor_ready, i_memmgmt_en, i_bus_en, i_monitor_en} = 4'hf;
		{i_coproc_a, i_coproc_b, kind, i_sysreg_idx, i_dreg_idx} = '0;
		{i_reg_idx, fword, i_sysreg_wdata, i_reg_wdata} = '0;
		{i_context_address, i_exec_prio, i_memmgmt_prio} = '0;
		{i_bus_prio, i_monitor_prio} = '0;
		seed = 32'h26effac5;
		do_reset();
		sys_move(1'b0, 4'h1, 32'h0);
		check(o_sysreg_rdata, `FSC_RESET);
		// every access encoding in both privilege modes
		for (int k = 0; k < 8; k++) begin
			{i_privileged, i_coproc_a} <= k[2:0];
			i_coproc_b <= k[1:0];
			@(posedge i_clk);
			deny = k[1:0] != 2'h3 && !(k[1:0] == 2'h1 && k[2]);
			if (deny) begin
				q.push_back({3'b010, fp_check_pkg::EXC_USAGE});
			end
			run_instr(1, went);
			repeat (2) @(posedge i_clk);
			check({went, o_no_coproc_flag}, {!deny, deny});
			i_status_clear <= 1'b1;
			@(posedge i_clk);
			{i_status_clear, i_coproc_b} <= {1'b0, 2'h0};
			@(posedge i_clk);
			check(o_config_error, k[1:0] != 2'h0);
		end
		{i_coproc_a, i_coproc_b} <= 4'hf;
		seed = lfsr(seed);
		fsc = seed;
		sys_move(1'b1, 4'h1, fsc);
		sys_move(1'b1, 4'h2, ~fsc);
		sys_move(1'b0, 4'h2, 32'h0);
		check(o_sysreg_rdata, 32'h0);
		sys_move(1'b0, 4'h1, 32'h0);
		check(o_sysreg_rdata, fsc);
		// fill singles 0 to 15, then read one double
		for (int k = 0; k < 16; k++) begin
			seed = lfsr(seed);
			sreg[k] = seed;
			{i_reg_wr, i_reg_idx, i_reg_wdata} <= {1'b1, 5'(k), seed};
			@(posedge i_clk);
		end
		{i_reg_wr, i_dreg_idx} <= {1'b0, 4'h3};
		@(posedge i_clk);
		check(o_dreg_rdata, {sreg[7], sreg[6]});
		save_case(1'b0, 2'h0, 5'h1f, 4'hf, 9'sd8, 9'sd2, 6'h00);
		for (int k = 0; k < 17; k++) begin
			check({mem.saved_addr[k], mem.saved_data[k]},
				{i_context_address + 32'(4 * k),
				k < 16 ? sreg[k % 16] : fsc});
		end
		save_case(1'b1, 2'h1, 5'h05, 4'hf, 9'sd8, 9'sd2, 6'h12);
		save_case(1'b1, 2'h2, 5'h00, 4'hf, 9'sd8, 9'sd20, 6'h0b);
		save_case(1'b1, 2'h1, 5'h10, 4'hb, 9'sd8, 9'sd2, 6'h14);
		save_case(1'b1, 2'h1, 5'h0f, 4'h1, -9'sd1, 9'sd2, 6'h20);
		save_case(1'b1, 2'h3, 5'h03, 4'hf, 9'sd8, 9'sd1, 6'h15);
		save_case(1'b1, 2'h3, 5'h03, 4'he, 9'sd8, 9'sd1, 6'h00);
		wrap_up();
	end
endmodule : tb_top
